// *** src/ltc_map.vh ***
/*
  Constants for the limit-alarm output block: APB register offsets, field
  positions, source-select codes and reset values.
  Assumes it is included by bare name from each design file that needs it.
*/
// Notes on behaviour
// - reference source follows its on/off bit, readable
// - reference source off after reset
// - alarm 1 upper window, alarm 2 lower
// - per-output polarity: failure drives high or low
// - polarity resets to active-low
// - polarity readback: 1 high, 0 low
// - per-output source: lower, upper or either
// - either-choice asserts on OR of failures
// - source resets to upper-bound failure
// - source readback returns the code in effect
// - independent enable per alarm output
// - both alarm outputs disabled after reset
// - enable readback: 1 enabled, 0 disabled
// - compare power against limits continuously, flag failures
`ifndef LTC_MAP_VH
`define LTC_MAP_VH

// ****************************************************************
// bus and data widths
// ****************************************************************
`define LTC_ADDR_W 8
`define LTC_PWR_W 16
`define LTC_IRQ_W 4

// ****************************************************************
// register byte offsets
// ****************************************************************
`define LTC_OFS_REF 8'h00
`define LTC_OFS_CFG1 8'h04
`define LTC_OFS_CFG2 8'h08
`define LTC_OFS_W1_LOW 8'h0c
`define LTC_OFS_W1_HIGH 8'h10
`define LTC_OFS_W2_LOW 8'h14
`define LTC_OFS_W2_HIGH 8'h18
`define LTC_OFS_STATUS 8'h1c
`define LTC_OFS_IRQ_STAT 8'h20
`define LTC_OFS_IRQ_CLR 8'h24
`define LTC_OFS_IRQ_EN 8'h28

// ****************************************************************
// field positions
// ****************************************************************
`define LTC_REF_ON 0
`define LTC_CFG_EN 0
`define LTC_CFG_POL 1
`define LTC_CFG_FEED_LO 2
`define LTC_CFG_FEED_HI 3
`define LTC_ST_W1_LOW 0
`define LTC_ST_W1_HIGH 1
`define LTC_ST_W2_LOW 2
`define LTC_ST_W2_HIGH 3
`define LTC_ST_ALM1 4
`define LTC_ST_ALM2 5
`define LTC_ST_REF 6

// ****************************************************************
// source-select codes and reset values
// ****************************************************************
`define LTC_FEED_LOW 2'h0
`define LTC_FEED_UPP 2'h1
`define LTC_FEED_BOTH 2'h2
`define LTC_RST_FEED 2'h1
`define LTC_RST_POL 1'h0
`define LTC_RST_EN 1'h0
`define LTC_RST_REF 1'h0
`define LTC_RST_LOW_LIM 16'h8000
`define LTC_RST_HIGH_LIM 16'h7fff
`define LTC_RST_ALARM 1'h1
`define LTC_ZERO32 32'h0000_0000

`endif

// *** src/ltc_limit_cmp.v ***
/*
  One window's limit comparator: flags power below the low bound and
  above the high bound, registered.
  Assumes power and limits are signed two's complement, synchronous to clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ltc_map.vh"

module ltc_limit_cmp (
  input wire clk,
  input wire rst,
  input wire [`LTC_PWR_W-1:0] power,
  input wire [`LTC_PWR_W-1:0] low_lim,
  input wire [`LTC_PWR_W-1:0] high_lim,
  output reg low_fail_q,
  output reg high_fail_q
);

  // ****************************************************************
  // comparison
  // ****************************************************************
  // compared every cycle, so a failure is flagged one edge after the sample
  always @(posedge clk) begin
    if (rst) begin
      low_fail_q <= 1'b0;
      high_fail_q <= 1'b0;
    end else begin
      low_fail_q <= ($signed(power) < $signed(low_lim));
      high_fail_q <= ($signed(power) > $signed(high_lim));
    end
  end

endmodule
`default_nettype wire

// *** src/ltc_alarm_drv.v ***
/*
  One alarm output driver: picks the failure source, applies enable and
  polarity, and registers the pin level.
  Assumes feed holds only legal codes; the register file refuses others.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ltc_map.vh"

module ltc_alarm_drv (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire active_high,
  input wire [1:0] feed,
  input wire low_fail,
  input wire high_fail,
  output reg alarm_q
);

  reg selected;

  // ****************************************************************
  // source selection
  // ****************************************************************
  // code 3 cannot be stored, the default only keeps the mux complete
  always @* begin
    case (feed)
      `LTC_FEED_LOW: selected = low_fail;
      `LTC_FEED_UPP: selected = high_fail;
      `LTC_FEED_BOTH: selected = low_fail | high_fail;
      default: selected = 1'b0;
    endcase
  end

  // ****************************************************************
  // pin level
  // ****************************************************************
  // idle level is the inverse of the active level, so reset shows high
  always @(posedge clk) begin
    if (rst) begin
      alarm_q <= `LTC_RST_ALARM;
    end else begin
      alarm_q <= (enable & selected) ^ ~active_high;
    end
  end

endmodule
`default_nettype wire

// *** src/ltc_top.v ***
/*
  Limit-alarm output block top: APB register file, reference source
  switch, two window comparators, two alarm drivers and an interrupt.
  Assumes one clock, synchronous active-high reset, and power samples
  and APB signals synchronous to core_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ltc_map.vh"

module ltc_top (
  input wire core_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LTC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [`LTC_PWR_W-1:0] upper_window_power,
  input wire [`LTC_PWR_W-1:0] lower_window_power,
  output wire upper_window_alarm_out,
  output wire lower_window_alarm_out,
  output wire reference_source_switch_cmd,
  output wire irq
);

  // ****************************************************************
  // functions
  // ****************************************************************
  // byte-lane merge, shared by every writable register except the interrupt clear, which takes pwdata whole
  function [31:0] fn_merge;
    input [31:0] old;
    input [31:0] wdata;
    input [3:0] strb;
    integer i;
    begin
      fn_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          fn_merge[i*8 +: 8] = wdata[i*8 +: 8];
        end
      end
    end
  endfunction

  // only the three selector codes are legal
  function fn_feed_ok;
    input [1:0] code;
    begin
      fn_feed_ok = (code == `LTC_FEED_LOW) || (code == `LTC_FEED_UPP) ||
        (code == `LTC_FEED_BOTH);
    end
  endfunction

  // address decode, also used for the error answer
  function fn_mapped;
    input [`LTC_ADDR_W-1:0] addr;
    begin
      case (addr)
        `LTC_OFS_REF, `LTC_OFS_CFG1, `LTC_OFS_CFG2,
        `LTC_OFS_W1_LOW, `LTC_OFS_W1_HIGH, `LTC_OFS_W2_LOW,
        `LTC_OFS_W2_HIGH, `LTC_OFS_STATUS, `LTC_OFS_IRQ_STAT,
        `LTC_OFS_IRQ_CLR, `LTC_OFS_IRQ_EN: fn_mapped = 1'b1;
        default: fn_mapped = 1'b0;
      endcase
    end
  endfunction

  // ****************************************************************
  // declarations
  // ****************************************************************
  reg ref_on_q;
  reg en1_q;
  reg pol1_q;
  reg [1:0] feed1_q;
  reg en2_q;
  reg pol2_q;
  reg [1:0] feed2_q;
  reg [`LTC_PWR_W-1:0] w1_low_q;
  reg [`LTC_PWR_W-1:0] w1_high_q;
  reg [`LTC_PWR_W-1:0] w2_low_q;
  reg [`LTC_PWR_W-1:0] w2_high_q;
  reg [`LTC_IRQ_W-1:0] irq_stat_q;
  reg [`LTC_IRQ_W-1:0] irq_stat_d;
  reg [`LTC_IRQ_W-1:0] irq_en_q;
  reg [`LTC_IRQ_W-1:0] fail_prev_q;
  reg [31:0] prdata_d;
  reg [31:0] cfg1_m;
  reg [31:0] cfg2_m;
  reg [31:0] ref_m;
  reg [31:0] lim_m;
  reg [31:0] irq_m;
  wire wr_access;
  wire setup_rd;
  wire upper_window_low_bound_fail;
  wire upper_window_high_bound_fail;
  wire lower_window_low_bound_fail;
  wire lower_window_high_bound_fail;
  wire alarm1_pin;
  wire alarm2_pin;
  wire [`LTC_IRQ_W-1:0] fail_now;
  wire [`LTC_IRQ_W-1:0] fail_rise;
  wire [`LTC_IRQ_W-1:0] irq_clr;

  // ****************************************************************
  // apb handshake
  // ****************************************************************
  // zero wait states: the access phase always completes at its first edge
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~fn_mapped(paddr);
  assign wr_access = psel & penable & pwrite & fn_mapped(paddr);
  assign setup_rd = psel & ~penable & ~pwrite;

  // merged write values for each register shape
  always @* begin
    ref_m = fn_merge({31'h0000_0000, ref_on_q}, pwdata, pstrb);
    cfg1_m = fn_merge({28'h000_0000, feed1_q, pol1_q, en1_q}, pwdata, pstrb);
    cfg2_m = fn_merge({28'h000_0000, feed2_q, pol2_q, en2_q}, pwdata, pstrb);
    irq_m = fn_merge({28'h000_0000, irq_en_q}, pwdata, pstrb);
    case (paddr)
      `LTC_OFS_W1_LOW: lim_m = fn_merge({16'h0000, w1_low_q}, pwdata, pstrb);
      `LTC_OFS_W1_HIGH: lim_m = fn_merge({16'h0000, w1_high_q}, pwdata, pstrb);
      `LTC_OFS_W2_LOW: lim_m = fn_merge({16'h0000, w2_low_q}, pwdata, pstrb);
      `LTC_OFS_W2_HIGH: lim_m = fn_merge({16'h0000, w2_high_q}, pwdata, pstrb);
      default: lim_m = `LTC_ZERO32;
    endcase
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // an illegal source code leaves the previous selection in force
  always @(posedge core_clk) begin
    if (sys_rst) begin
      ref_on_q <= `LTC_RST_REF;
      en1_q <= `LTC_RST_EN;
      en2_q <= `LTC_RST_EN;
      pol1_q <= `LTC_RST_POL;
      pol2_q <= `LTC_RST_POL;
      feed1_q <= `LTC_RST_FEED;
      feed2_q <= `LTC_RST_FEED;
      w1_low_q <= `LTC_RST_LOW_LIM;
      w1_high_q <= `LTC_RST_HIGH_LIM;
      w2_low_q <= `LTC_RST_LOW_LIM;
      w2_high_q <= `LTC_RST_HIGH_LIM;
      irq_en_q <= {`LTC_IRQ_W{1'b0}};
    end else if (wr_access) begin
      case (paddr)
        `LTC_OFS_REF: begin
          ref_on_q <= ref_m[`LTC_REF_ON];
        end
        `LTC_OFS_CFG1: begin
          en1_q <= cfg1_m[`LTC_CFG_EN];
          pol1_q <= cfg1_m[`LTC_CFG_POL];
          if (fn_feed_ok(cfg1_m[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO])) begin
            feed1_q <= cfg1_m[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO];
          end
        end
        `LTC_OFS_CFG2: begin
          en2_q <= cfg2_m[`LTC_CFG_EN];
          pol2_q <= cfg2_m[`LTC_CFG_POL];
          if (fn_feed_ok(cfg2_m[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO])) begin
            feed2_q <= cfg2_m[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO];
          end
        end
        `LTC_OFS_W1_LOW: begin
          w1_low_q <= lim_m[`LTC_PWR_W-1:0];
        end
        `LTC_OFS_W1_HIGH: begin
          w1_high_q <= lim_m[`LTC_PWR_W-1:0];
        end
        `LTC_OFS_W2_LOW: begin
          w2_low_q <= lim_m[`LTC_PWR_W-1:0];
        end
        `LTC_OFS_W2_HIGH: begin
          w2_high_q <= lim_m[`LTC_PWR_W-1:0];
        end
        `LTC_OFS_IRQ_EN: begin
          irq_en_q <= irq_m[`LTC_IRQ_W-1:0];
        end
        default: begin
          ref_on_q <= ref_on_q;
        end
      endcase
    end
  end

  assign reference_source_switch_cmd = ref_on_q;

  // ****************************************************************
  // window comparators
  // ****************************************************************
  // each window keeps its own pair of bounds
  ltc_limit_cmp u_cmp_upper (
    .clk(core_clk),
    .rst(sys_rst),
    .power(upper_window_power),
    .low_lim(w1_low_q),
    .high_lim(w1_high_q),
    .low_fail_q(upper_window_low_bound_fail),
    .high_fail_q(upper_window_high_bound_fail)
  );

  ltc_limit_cmp u_cmp_lower (
    .clk(core_clk),
    .rst(sys_rst),
    .power(lower_window_power),
    .low_lim(w2_low_q),
    .high_lim(w2_high_q),
    .low_fail_q(lower_window_low_bound_fail),
    .high_fail_q(lower_window_high_bound_fail)
  );

  // ****************************************************************
  // alarm drivers
  // ****************************************************************
  // wiring is fixed: driver 1 sees only the upper window, 2 the lower
  ltc_alarm_drv u_alarm1 (
    .clk(core_clk),
    .rst(sys_rst),
    .enable(en1_q),
    .active_high(pol1_q),
    .feed(feed1_q),
    .low_fail(upper_window_low_bound_fail),
    .high_fail(upper_window_high_bound_fail),
    .alarm_q(alarm1_pin)
  );

  ltc_alarm_drv u_alarm2 (
    .clk(core_clk),
    .rst(sys_rst),
    .enable(en2_q),
    .active_high(pol2_q),
    .feed(feed2_q),
    .low_fail(lower_window_low_bound_fail),
    .high_fail(lower_window_high_bound_fail),
    .alarm_q(alarm2_pin)
  );

  assign upper_window_alarm_out = alarm1_pin;
  assign lower_window_alarm_out = alarm2_pin;

  // ****************************************************************
  // interrupt
  // ****************************************************************
  // events are onsets of each failure flag, independent of output enables
  assign fail_now = {lower_window_high_bound_fail, lower_window_low_bound_fail,
    upper_window_high_bound_fail, upper_window_low_bound_fail};
  assign fail_rise = fail_now & ~fail_prev_q;
  assign irq_clr = (wr_access && (paddr == `LTC_OFS_IRQ_CLR)) ?
    pwdata[`LTC_IRQ_W-1:0] : {`LTC_IRQ_W{1'b0}};

  // a new event in the clearing cycle survives the clear
  always @* begin
    irq_stat_d = (irq_stat_q & ~irq_clr) | fail_rise;
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_stat_q <= {`LTC_IRQ_W{1'b0}};
      fail_prev_q <= {`LTC_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= irq_stat_d;
      fail_prev_q <= fail_now;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ****************************************************************
  // read data
  // ****************************************************************
  // sampled in the setup cycle so prdata is a flop during the access
  always @* begin
    prdata_d = `LTC_ZERO32;
    case (paddr)
      `LTC_OFS_REF: prdata_d[`LTC_REF_ON] = ref_on_q;
      `LTC_OFS_CFG1: begin
        prdata_d[`LTC_CFG_EN] = en1_q;
        prdata_d[`LTC_CFG_POL] = pol1_q;
        prdata_d[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO] = feed1_q;
      end
      `LTC_OFS_CFG2: begin
        prdata_d[`LTC_CFG_EN] = en2_q;
        prdata_d[`LTC_CFG_POL] = pol2_q;
        prdata_d[`LTC_CFG_FEED_HI:`LTC_CFG_FEED_LO] = feed2_q;
      end
      `LTC_OFS_W1_LOW: prdata_d[`LTC_PWR_W-1:0] = w1_low_q;
      `LTC_OFS_W1_HIGH: prdata_d[`LTC_PWR_W-1:0] = w1_high_q;
      `LTC_OFS_W2_LOW: prdata_d[`LTC_PWR_W-1:0] = w2_low_q;
      `LTC_OFS_W2_HIGH: prdata_d[`LTC_PWR_W-1:0] = w2_high_q;
      `LTC_OFS_STATUS: begin
        prdata_d[`LTC_ST_W2_HIGH:`LTC_ST_W1_LOW] = fail_now;
        prdata_d[`LTC_ST_ALM1] = alarm1_pin;
        prdata_d[`LTC_ST_ALM2] = alarm2_pin;
        prdata_d[`LTC_ST_REF] = ref_on_q;
      end
      `LTC_OFS_IRQ_STAT: prdata_d[`LTC_IRQ_W-1:0] = irq_stat_q;
      `LTC_OFS_IRQ_EN: prdata_d[`LTC_IRQ_W-1:0] = irq_en_q;
      default: prdata_d = `LTC_ZERO32;
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= `LTC_ZERO32;
    end else if (setup_rd) begin
      prdata <= prdata_d;
    end
  end

endmodule
`default_nettype wire

// *** sim/ltc_top_sva.sv ***
/*
  Port-level checker for the limit-alarm block, bound into ltc_top.
  Assumes the bench writes full words (all strobes) and only legal or
  refused source codes; shadows config and limits from APB writes.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ltc_map.vh"

module ltc_top_sva (
  input wire core_clk,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LTC_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [`LTC_PWR_W-1:0] upper_window_power,
  input wire [`LTC_PWR_W-1:0] lower_window_power,
  input wire upper_window_alarm_out,
  input wire lower_window_alarm_out,
  input wire reference_source_switch_cmd,
  input wire irq
);
  // ****************************************************************
  // shadow state
  // ****************************************************************
  logic [3:0] cfg1_q, cfg2_q, fail_q;
  logic [15:0] lim_q [0:3];
  logic [7:0] lim_idx;
  wire wr_en = psel && penable && pwrite && (pstrb == 4'hf);
  assign lim_idx = paddr - `LTC_OFS_W1_LOW;

  // code 3 is refused: the source field keeps its old value
  function logic [3:0] cfg_nxt(input logic [3:0] old, input logic [31:0] d);
    cfg_nxt = (d[3:2] == 2'h3) ? {old[3:2], d[1:0]} : d[3:0];
  endfunction

  // pin level from config and failure flags
  function logic pin(input logic [3:0] c, input logic lf, input logic hf);
    logic s;
    s = (c[3:2] == 2'h0) ? lf : (c[3:2] == 2'h1) ? hf : (lf | hf);
    pin = (c[0] & s) ^ ~c[1];
  endfunction

  // mirror of config, limits and flags; flags lag power by one edge
  always @(posedge core_clk) begin
    if (sys_rst) begin
      cfg1_q <= 4'h4;
      cfg2_q <= 4'h4;
      fail_q <= 4'h0;
      lim_q[0] <= 16'h8000;
      lim_q[1] <= 16'h7fff;
      lim_q[2] <= 16'h8000;
      lim_q[3] <= 16'h7fff;
    end else begin
      if (wr_en && paddr == `LTC_OFS_CFG1) cfg1_q <= cfg_nxt(cfg1_q, pwdata);
      if (wr_en && paddr == `LTC_OFS_CFG2) cfg2_q <= cfg_nxt(cfg2_q, pwdata);
      if (wr_en && lim_idx <= 8'h0c && lim_idx[1:0] == 2'h0) lim_q[lim_idx[3:2]] <= pwdata[15:0];
      fail_q <= {$signed(lower_window_power) > $signed(lim_q[3]),
                 $signed(lower_window_power) < $signed(lim_q[2]),
                 $signed(upper_window_power) > $signed(lim_q[1]),
                 $signed(upper_window_power) < $signed(lim_q[0])};
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_ref_follow: assert property (
    wr_en && paddr == `LTC_OFS_REF |=> reference_source_switch_cmd == $past(pwdata[0]))
    else $error("reference switch does not follow write");
  a_ref_readback: assert property (
    psel && penable && !pwrite && paddr == `LTC_OFS_REF |->
    prdata == {31'h0000_0000, reference_source_switch_cmd})
    else $error("reference readback wrong");
  a_ref_reset: assert property ($past(sys_rst) |-> !reference_source_switch_cmd)
    else $error("reference on after reset");
  a_alarm_reset: assert property (
    $past(sys_rst) |-> upper_window_alarm_out && lower_window_alarm_out)
    else $error("alarm not idle high after reset");
  a_upper_pin: assert property (
    upper_window_alarm_out == pin($past(cfg1_q), $past(fail_q[0]), $past(fail_q[1])))
    else $error("upper window alarm level wrong");
  a_lower_pin: assert property (
    lower_window_alarm_out == pin($past(cfg2_q), $past(fail_q[2]), $past(fail_q[3])))
    else $error("lower window alarm level wrong");
  a_cfg1_read: assert property (
    psel && penable && !pwrite && paddr == `LTC_OFS_CFG1 |-> prdata == {28'h000_0000, cfg1_q})
    else $error("output 1 config readback wrong");
  a_cfg2_read: assert property (
    psel && penable && !pwrite && paddr == `LTC_OFS_CFG2 |-> prdata == {28'h000_0000, cfg2_q})
    else $error("output 2 config readback wrong");
endmodule

bind ltc_top ltc_top_sva u_sva (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .upper_window_power, .lower_window_power,
  .upper_window_alarm_out, .lower_window_alarm_out, .reference_source_switch_cmd, .irq);
`default_nettype wire

// *** sim/ltc_alarm_sampler.sv ***
/*
  Far-side equipment model: samples both alarm levels on every rising clock edge.
  Assumes the alarm pins are plain push-pull levels, no pull resistors.
*/
`timescale 1ns/10ps
`default_nettype none

module ltc_alarm_sampler (
  input wire logic clk,
  input wire logic upper_in,
  input wire logic lower_in,
  output var logic upper_seen,
  output var logic lower_seen
);
  // ****************************************************************
  // sampling
  // ****************************************************************
  // one flop of latency, as real equipment would add at least that
  always @(posedge clk) begin
    upper_seen <= upper_in;
    lower_seen <= lower_in;
  end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
/*
  Self-checking bench for ltc_top: APB master, random config and power
  with limit-edge corners, interrupt raise/mask/clear.
  Assumes the checker is bound in and the sampler models the far side.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ltc_map.vh"

module testbench;
  // ****************************************************************
  // stimulus and checks
  // ****************************************************************
  logic core_clk, sys_rst, psel, penable, pwrite, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb, c1, c2;
  logic [15:0] upw, lpw;
  logic [15:0] lim [0:3];
  wire [31:0] prdata;
  wire pready, pslverr, alm_up, alm_lo, ref_cmd, irq, seen_up, seen_lo;
  integer seed, miscompares, n_tests, i;

  ltc_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .upper_window_power(upw),
    .lower_window_power(lpw), .upper_window_alarm_out(alm_up),
    .lower_window_alarm_out(alm_lo), .reference_source_switch_cmd(ref_cmd), .irq(irq));
  ltc_alarm_sampler u_far (.clk(core_clk), .upper_in(alm_up), .lower_in(alm_lo),
    .upper_seen(seen_up), .lower_seen(seen_lo));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // one transfer; read data and error taken at the pready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // only legal source codes 0..2 are ever drawn
  function logic [3:0] rnd_cfg();
    logic [31:0] r;
    r = $random(seed);
    rnd_cfg = {2'(r[15:8] % 8'd3), r[1:0]};
  endfunction

  // limit edges are the likely off-by-one spots, so favour them
  function logic [15:0] pick(input logic [15:0] lo, input logic [15:0] hi);
    logic [31:0] r;
    r = $random(seed);
    case (r[2:0])
      3'h0: pick = lo - 16'h0001;
      3'h1: pick = lo;
      3'h2: pick = hi;
      3'h3: pick = hi + 16'h0001;
      default: pick = r[31:16];
    endcase
  endfunction

  function logic exp_alm(input logic [3:0] c, input logic [15:0] pw, lo, hi);
    logic lf, hf, s;
    lf = $signed(pw) < $signed(lo);
    hf = $signed(pw) > $signed(hi);
    s = (c[3:2] == 2'h0) ? lf : (c[3:2] == 2'h1) ? hf : (lf | hf);
    exp_alm = (c[0] & s) ^ ~c[1];
  endfunction

  task complete_run();
    $display("comparisons %0d, miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // cuts a hang short; the run needs well under 5000 cycles
  initial begin
    repeat (30000) @(posedge core_clk);
    miscompares++;
    complete_run();
  end

  initial begin
    seed = 32'hd793;
    miscompares = 0;
    n_tests = 0;
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    pstrb = 4'hf;
    upw = 16'h0000;
    lpw = 16'h0100;
    lim = '{16'hff9c, 16'h0064, 16'h0010, 16'h0200};
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    chk1(alm_up, 1'b1);
    chk1(alm_lo, 1'b1);
    chk1(ref_cmd, 1'b0);
    apb(1'b0, `LTC_OFS_CFG1, 32'h0);
    chk32(rd, 32'h0000_0004);
    apb(1'b0, `LTC_OFS_CFG2, 32'h0);
    chk32(rd, 32'h0000_0004);
    apb(1'b0, 8'h2c, 32'h0);
    chk1(err, 1'b1);
    apb(1'b1, `LTC_OFS_REF, 32'h1);
    apb(1'b0, `LTC_OFS_REF, 32'h0);
    chk32(rd, 32'h0000_0001);
    chk1(ref_cmd, 1'b1);
    apb(1'b1, `LTC_OFS_REF, 32'h0);
    apb(1'b0, `LTC_OFS_REF, 32'h0);
    chk32(rd, 32'h0000_0000);
    chk1(ref_cmd, 1'b0);
    for (i = 0; i < 4; i++) apb(1'b1, `LTC_OFS_W1_LOW + 8'(4 * i), {16'h0000, lim[i]});
    for (i = 0; i < 80; i++) begin
      c1 = rnd_cfg();
      c2 = rnd_cfg();
      apb(1'b1, `LTC_OFS_CFG1, {28'h000_0000, c1});
      apb(1'b1, `LTC_OFS_CFG2, {28'h000_0000, c2});
      apb(1'b0, `LTC_OFS_CFG1, 32'h0);
      chk32(rd, {28'h000_0000, c1});
      apb(1'b0, `LTC_OFS_CFG2, 32'h0);
      chk32(rd, {28'h000_0000, c2});
      upw <= pick(lim[0], lim[1]);
      lpw <= pick(lim[2], lim[3]);
      repeat (4) @(posedge core_clk);
      chk1(seen_up, exp_alm(c1, upw, lim[0], lim[1]));
      chk1(seen_lo, exp_alm(c2, lpw, lim[2], lim[3]));
    end
    // refused source code: enable and polarity land, source stays
    apb(1'b1, `LTC_OFS_CFG1, 32'h0000_000d);
    apb(1'b0, `LTC_OFS_CFG1, 32'h0);
    chk32(rd, {28'h000_0000, c1[3:2], 2'b01});
    upw <= 16'h0000;
    lpw <= 16'h0100;
    apb(1'b1, `LTC_OFS_IRQ_CLR, 32'h0000_000f);
    apb(1'b1, `LTC_OFS_IRQ_EN, 32'h0000_0001);
    chk1(irq, 1'b0);
    upw <= 16'hff00;
    repeat (4) @(posedge core_clk);
    chk1(irq, 1'b1);
    apb(1'b0, `LTC_OFS_IRQ_STAT, 32'h0);
    chk32(rd, 32'h0000_0001);
    apb(1'b1, `LTC_OFS_IRQ_EN, 32'h0);
    apb(1'b0, `LTC_OFS_IRQ_STAT, 32'h0);
    chk32(rd, 32'h0000_0001);
    chk1(irq, 1'b0);
    apb(1'b1, `LTC_OFS_IRQ_EN, 32'h0000_0001);
    apb(1'b1, `LTC_OFS_IRQ_CLR, 32'h0000_0001);
    apb(1'b0, `LTC_OFS_IRQ_STAT, 32'h0);
    chk32(rd, 32'h0000_0000);
    chk1(irq, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
